/* logic/mis_pkg.sv */
/*
 * Shared constants of the memory integrity scanner: register offsets,
 * field positions, reset values, checksum constants and the start delay.
 * Assumes an 8-bit register port with byte-wide registers.
 */
package mis_pkg;
	localparam int REG_AW = 2;
	localparam logic [REG_AW-1:0] OFS_CONTROL = 2'h0;
	localparam logic [REG_AW-1:0] OFS_REGION = 2'h1;
	localparam logic [REG_AW-1:0] OFS_STATUS = 2'h2;

	localparam int CTL_ENABLE = 0;
	localparam int CTL_ARM = 1;
	localparam int CTL_STROBE = 7;
	localparam int STS_BUSY = 0;
	localparam int STS_PASS = 1;
	localparam int RGN_SRC_LO = 0;
	localparam int RGN_MODE_LO = 4;

	localparam logic [7:0] RST_CONTROL = 8'h00;
	localparam logic [7:0] RST_REGION = 8'h00;
	localparam logic [7:0] RST_STATUS = 8'h02;

	localparam logic [1:0] SRC_ENTIRE = 2'h0;
	localparam logic [1:0] SRC_LOADER_AND_PROGRAM = 2'h1;
	localparam logic [1:0] SRC_LOADER = 2'h2;
	localparam logic [1:0] MODE_PRIORITY = 2'h0;
	localparam logic [1:0] MODE_STARTUP = 2'h1;

	localparam logic [15:0] CRC_POLY = 16'h1021;
	localparam logic [15:0] CRC_INIT = 16'hffff;
	localparam logic [1:0] START_DLY_CYC = 2'h3;

	typedef enum logic [4:0] {
		S_IDLE = 5'b00001,
		S_DELAY = 5'b00010,
		S_FETCH = 5'b00100,
		S_ACK = 5'b01000,
		S_CHECK = 5'b10000
	} mis_state_t;
endpackage

/* logic/mis_crc_if.sv */
/*
 * Byte stream from the scan sequencer into the checksum engine.
 * Assumes both ends share one clock.
 */
`timescale 1ns/1ps
interface mis_crc_if;
	logic init;
	logic vld;
	logic [7:0] data;
	logic [15:0] crc;
	modport ctl (output init, output vld, output data, input crc);
	modport eng (input init, input vld, input data, output crc);
endinterface

/* logic/mis_crc_engine.sv */
/*
 * Checksum engine: x16+x12+x5+1, one byte per cycle, msb first.
 * Assumes the sequencer pulses init before the first byte.
 */
`timescale 1ns/1ps
module mis_crc_engine (
	input wire logic clk_i,
	input wire logic rst_n_i,
	mis_crc_if.eng crc_bus
);
	import mis_pkg::*;

	typedef struct packed {
		logic [15:0] crc;
	} mis_eng_st_t;

	mis_eng_st_t st_ff;
	mis_eng_st_t nxt_st;

	function automatic logic [15:0] crc_byte(input logic [15:0] c,
		input logic [7:0] d);
		logic [15:0] r;
		logic fb;
		r = c;
		for (int i = 7; i >= 0; i--) begin
			fb = r[15] ^ d[i];
			r = {r[14:0], 1'b0} ^ (fb ? CRC_POLY : 16'h0000);
		end
		return r;
	endfunction

	always_comb begin
		nxt_st = st_ff;
		if (crc_bus.init) begin
			nxt_st.crc = CRC_INIT;
		end else if (crc_bus.vld) begin
			nxt_st.crc = crc_byte(st_ff.crc, crc_bus.data);
		end
	end

	always_ff @(posedge clk_i or negedge rst_n_i) begin
		if (!rst_n_i) begin
			st_ff <= '{crc: CRC_INIT};
		end else begin
			st_ff <= nxt_st;
		end
	end

	assign crc_bus.crc = st_ff.crc;
endmodule

/* logic/mis_scanner.sv */
/*
 * Memory integrity scanner: control, region and status registers, the
 * scan sequencer over a byte-wide flash read port, cpu stall and the
 * failure interrupt request.
 * Assumes flash answers each read with flash_ack_i one or more cycles
 * later, and region end addresses are at least 2.
 */
`timescale 1ns/1ps
// Overview of operation
// - reset strobe clears enable, region and status one cycle after write
// - with arm clear, reset strobe is taken even while scanning
// - with arm set, reset strobe during a scan is ignored
// - with arm set, any checksum mismatch raises the failure interrupt
// - arm bit cleared only by system reset, not by reset strobe
// - arm bit can be set only while no scan runs
// - after a failure interrupt, control register writes are ignored
// - writing enable one while idle starts a scan; bit stays one afterwards
// - writing enable zero changes nothing
// - after a start-up scan the enable bit reads one
// - region register ignores writes while busy or after interrupt
// - mode zero is a single priority scan stalling the cpu
// - after start-up scan mode reads non-zero; software rewrites zero
// - region field: 0 entire, 1 loader and program, 2 loader only
// - after start-up scan region field shows the strapped region
// - pass flag reads one after success and before any scan
// - busy flag reads one while a scan runs
// - checksum x16+x12+x5+1, init all ones, bytes msb first from zero
// - result compared with 16-bit value in last region bytes
// - scan begins three cycles after enable; cpu keeps running meanwhile
// - failure interrupt stays asserted until system reset
module mis_scanner #(
	parameter int AW = 16,
	parameter logic [AW-1:0] FLASH_END = 16'h0fff
) (
	input wire logic clk_i,
	input wire logic rst_n_i,
	input wire logic [mis_pkg::REG_AW-1:0] reg_addr_i,
	input wire logic [7:0] reg_wdata_i,
	input wire logic reg_wr_i,
	input wire logic reg_rd_i,
	output logic [7:0] reg_rdata_o,
	input wire logic [AW-1:0] loader_end_i,
	input wire logic [AW-1:0] program_end_i,
	input wire logic startup_scan_i,
	input wire logic [1:0] startup_region_i,
	output logic flash_rd_o,
	output logic [AW-1:0] flash_addr_o,
	input wire logic flash_ack_i,
	input wire logic [7:0] flash_rdata_i,
	output logic cpu_stall_o,
	output logic nmi_o,
	output logic busy_o
);
	import mis_pkg::*;

	typedef struct packed {
		mis_state_t st;
		logic [1:0] dly;
		logic [AW-1:0] addr;
		logic [15:0] stored;
		logic en;
		logic arm;
		logic [1:0] mode;
		logic [1:0] src;
		logic ok;
		logic nmi;
		logic boot_done;
		logic [7:0] rdata;
	} mis_top_st_t;

	mis_top_st_t st_ff;
	mis_top_st_t nxt_st;
	mis_crc_if crc_bus ();

	logic busy;
	logic wr_ctl;
	logic wr_rgn;
	logic strobe_ok;
	logic [AW-1:0] last;
	logic mismatch;
	logic [7:0] ctl_view;
	logic [7:0] rgn_view;
	logic [7:0] sts_view;

	mis_crc_engine u_crc (
		.clk_i(clk_i),
		.rst_n_i(rst_n_i),
		.crc_bus(crc_bus)
	);

	assign busy = (st_ff.st != S_IDLE);
	assign wr_ctl = reg_wr_i && (reg_addr_i == OFS_CONTROL);
	assign wr_rgn = reg_wr_i && (reg_addr_i == OFS_REGION);
	// strobe: any time with arm clear, only idle with arm set
	assign strobe_ok = wr_ctl && !st_ff.nmi && reg_wdata_i[CTL_STROBE]
		&& (!st_ff.arm || !busy);
	assign mismatch = (crc_bus.crc != st_ff.stored);
	assign ctl_view = {6'h00, st_ff.arm, st_ff.en};
	assign rgn_view = {2'h0, st_ff.mode, 2'h0, st_ff.src};
	assign sts_view = {6'h00, st_ff.ok, busy};

	always_comb begin
		case (st_ff.src)
			SRC_LOADER_AND_PROGRAM: last = program_end_i;
			SRC_LOADER: last = loader_end_i;
			default: last = FLASH_END;
		endcase
	end

	always_comb begin
		nxt_st = st_ff;
		crc_bus.init = 1'b0;
		crc_bus.vld = 1'b0;
		crc_bus.data = flash_rdata_i;
		flash_rd_o = 1'b0;

		// read data stand only in the cycle after the read strobe
		nxt_st.rdata = 8'h00;
		if (reg_rd_i) begin
			case (reg_addr_i)
				OFS_CONTROL: nxt_st.rdata = ctl_view;
				OFS_REGION: nxt_st.rdata = rgn_view;
				OFS_STATUS: nxt_st.rdata = sts_view;
				default: nxt_st.rdata = 8'h00;
			endcase
		end

		case (st_ff.st)
			S_IDLE: begin
				nxt_st.dly = 2'h0;
			end
			S_DELAY: begin
				// cpu not stalled here
				nxt_st.dly = st_ff.dly + 2'h1;
				if (st_ff.dly == START_DLY_CYC - 2'h1) begin
					nxt_st.st = S_FETCH;
				end
			end
			S_FETCH: begin
				flash_rd_o = 1'b1;
				nxt_st.st = S_ACK;
			end
			S_ACK: begin
				if (flash_ack_i) begin
					if (st_ff.addr == last) begin
						nxt_st.stored[7:0] = flash_rdata_i;
						nxt_st.st = S_CHECK;
					end else begin
						if (st_ff.addr == last - AW'(1)) begin
							nxt_st.stored[15:8] = flash_rdata_i;
						end else begin
							crc_bus.vld = 1'b1;
						end
						nxt_st.addr = st_ff.addr + AW'(1);
						nxt_st.st = S_FETCH;
					end
				end
			end
			S_CHECK: begin
				nxt_st.ok = !mismatch;
				if (mismatch && st_ff.arm) begin
					nxt_st.nmi = 1'b1;
				end
				nxt_st.st = S_IDLE;
			end
			default: nxt_st.st = S_IDLE;
		endcase

		// start-up scan, strap caught once after reset release
		if (!st_ff.boot_done) begin
			nxt_st.boot_done = 1'b1;
			if (startup_scan_i) begin
				nxt_st.en = 1'b1;
				nxt_st.src = startup_region_i;
				nxt_st.mode = MODE_STARTUP;
				nxt_st.addr = '0;
				crc_bus.init = 1'b1;
				nxt_st.st = S_FETCH;
			end
		end else if (strobe_ok) begin
			// clear all but arm; scan abandoned
			nxt_st.en = 1'b0;
			nxt_st.mode = 2'h0;
			nxt_st.src = 2'h0;
			nxt_st.ok = 1'b0;
			nxt_st.st = S_IDLE;
			nxt_st.arm = st_ff.arm;
		end else begin
			if (wr_ctl && !st_ff.nmi) begin
				if (reg_wdata_i[CTL_ARM] && !busy) begin
					nxt_st.arm = 1'b1;
				end
				// zero leaves enable and the scan alone
				if (reg_wdata_i[CTL_ENABLE]) begin
					nxt_st.en = 1'b1;
					if (!busy) begin
						nxt_st.addr = '0;
						nxt_st.dly = 2'h0;
						crc_bus.init = 1'b1;
						nxt_st.st = S_DELAY;
					end
				end
			end
			if (wr_rgn && !busy && !st_ff.nmi) begin
				nxt_st.mode = reg_wdata_i[RGN_MODE_LO +: 2];
				nxt_st.src = reg_wdata_i[RGN_SRC_LO +: 2];
			end
		end
	end

	always_ff @(posedge clk_i or negedge rst_n_i) begin
		if (!rst_n_i) begin
			st_ff.st <= S_IDLE;
			st_ff.dly <= 2'h0;
			st_ff.addr <= '0;
			st_ff.stored <= 16'h0000;
			st_ff.en <= RST_CONTROL[CTL_ENABLE];
			st_ff.arm <= RST_CONTROL[CTL_ARM];
			st_ff.mode <= RST_REGION[RGN_MODE_LO +: 2];
			st_ff.src <= RST_REGION[RGN_SRC_LO +: 2];
			st_ff.ok <= RST_STATUS[STS_PASS];
			st_ff.nmi <= 1'b0;
			st_ff.boot_done <= 1'b0;
			st_ff.rdata <= 8'h00;
		end else begin
			st_ff <= nxt_st;
		end
	end

	assign reg_rdata_o = st_ff.rdata;
	assign flash_addr_o = st_ff.addr;
	// mode zero and start-up scans both hold the cpu off flash
	assign cpu_stall_o = busy && (st_ff.st != S_DELAY);
	assign nmi_o = st_ff.nmi;
	assign busy_o = busy;

	default clocking cb @(posedge clk_i); endclocking
	default disable iff (!rst_n_i);

	sequence s_start_wr;
		st_ff.boot_done && wr_ctl && reg_wdata_i[CTL_ENABLE]
			&& !reg_wdata_i[CTL_STROBE] && !st_ff.nmi && !busy;
	endsequence
	sequence s_delay_run;
		(busy && !cpu_stall_o)[*3] ##1 cpu_stall_o;
	endsequence

	a_strobe_clears: assert property (
		st_ff.boot_done && strobe_ok |=> !busy && !st_ff.en
			&& rgn_view == 8'h00 && !st_ff.ok)
		else $error("reset strobe did not clear registers");
	a_strobe_refused: assert property (
		wr_ctl && reg_wdata_i[CTL_STROBE] && st_ff.arm && busy
			&& st_ff.st != S_CHECK |=> busy)
		else $error("reset strobe acted during armed scan");
	a_nmi_raise: assert property (
		st_ff.st == S_CHECK && mismatch && st_ff.arm |=> nmi_o && !st_ff.ok)
		else $error("mismatch with arm did not raise interrupt");
	a_arm_kept: assert property (
		st_ff.arm |=> st_ff.arm)
		else $error("arm bit dropped without system reset");
	a_arm_busy: assert property (
		busy && !st_ff.arm |=> !st_ff.arm)
		else $error("arm bit set during scan");
	a_nmi_lock: assert property (
		st_ff.nmi |=> $stable(ctl_view))
		else $error("control changed after interrupt");
	a_scan_start: assert property (
		s_start_wr |=> s_delay_run)
		else $error("scan did not begin three cycles after enable");
	a_nmi_sticky: assert property (
		nmi_o |=> nmi_o)
		else $error("interrupt request withdrawn");
	a_region_lock: assert property (
		busy && st_ff.boot_done |=> $stable(rgn_view) || !busy)
		else $error("region register changed during scan");
	a_unmapped_zero: assert property (
		reg_rd_i && reg_addr_i == 2'h3 |=> reg_rdata_o == 8'h00)
		else $error("unmapped read not zero");

	// start-up strap caught at first edge after release
	sequence s_boot_strap;
		rst_n_i && !st_ff.boot_done && startup_scan_i;
	endsequence
	sequence s_first_fetch;
		flash_rd_o && flash_addr_o == '0;
	endsequence

	a_first_fetch: assert property (
		s_start_wr |-> ##4 s_first_fetch)
		else $error("first fetch not at byte zero on fourth cycle");
	a_boot_scan: assert property (
		s_boot_strap |=> st_ff.en && cpu_stall_o
			&& st_ff.mode != MODE_PRIORITY)
		else $error("start-up scan did not start");
	a_boot_region: assert property (
		s_boot_strap |=> st_ff.src == $past(startup_region_i))
		else $error("start-up region not kept");
	a_enable_zero: assert property (
		st_ff.boot_done && wr_ctl && !reg_wdata_i[CTL_ENABLE]
			&& !strobe_ok |=> $stable(st_ff.en))
		else $error("enable changed by a zero write");
	a_enable_kept: assert property (
		st_ff.st == S_CHECK && !strobe_ok |=> st_ff.en)
		else $error("enable dropped at end of scan");
	a_pass_hold: assert property (
		busy && st_ff.st != S_CHECK && !strobe_ok
			|=> $stable(st_ff.ok))
		else $error("pass flag changed during scan");
	a_nmi_armed: assert property (
		!st_ff.arm && !nmi_o |=> !nmi_o)
		else $error("interrupt raised without arm");

	a_check_done: assert property (
		st_ff.st == S_CHECK |=> !busy_o && !cpu_stall_o)
		else $error("busy or stall held after check");

	// flash port: one outstanding read, address held until ack
	a_fetch_stall: assert property (
		flash_rd_o |-> cpu_stall_o)
		else $error("flash read without cpu stall");
	a_one_read: assert property (
		flash_rd_o |=> !flash_rd_o)
		else $error("second flash read before ack");
	a_addr_hold: assert property (
		st_ff.st == S_ACK && !flash_ack_i |=> $stable(flash_addr_o))
		else $error("flash address moved before ack");

	// register read-back
	a_busy_read: assert property (
		reg_rd_i && reg_addr_i == OFS_STATUS && busy
			|=> reg_rdata_o[STS_BUSY])
		else $error("busy flag read zero during scan");
	a_ctl_reserved: assert property (
		reg_rd_i && reg_addr_i == OFS_CONTROL
			|=> reg_rdata_o[7:2] == 6'h00)
		else $error("control strobe or reserved bits read non-zero");
	a_rgn_reserved: assert property (
		reg_rd_i && reg_addr_i == OFS_REGION
			|=> reg_rdata_o[7:6] == 2'h0 && reg_rdata_o[3:2] == 2'h0)
		else $error("region reserved bits read non-zero");
endmodule

/* sim/mis_flash_model.sv */
/*
 * Flash read port model: byte memory that answers each read promptly
 * or after a random slow latency.
 * Assumes one-cycle read pulses with the address held until the ack.
 */
`timescale 1ns/1ps
module mis_flash_model (
	input wire logic clk_i,
	input wire logic rd_i,
	input wire logic [15:0] addr_i,
	input wire logic slow_i,
	output logic ack_o,
	output logic [7:0] rdata_o
);
	logic [7:0] mem [0:255];
	logic [7:0] a;
	initial begin
		ack_o = 1'b0;
		rdata_o = 8'h00;
		forever begin
			@(negedge clk_i);
			if (rd_i === 1'b1) begin
				a = addr_i[7:0];
				@(posedge clk_i);
				repeat (slow_i ? $urandom_range(1, 4) : 0) @(posedge clk_i);
				ack_o <= 1'b1;
				rdata_o <= mem[a];
				@(posedge clk_i);
				ack_o <= 1'b0;
				// released data shows its inverse
				rdata_o <= ~mem[a];
			end
		end
	end
endmodule

/* sim/program_memory_crc_scan_bench.sv */
/*
 * Self-checking bench of the memory integrity scanner with a flash model.
 * Assumes the register port answers reads one cycle after the strobe.
 */
`timescale 1ns/1ps
module program_memory_crc_scan_bench;
	import mis_pkg::*;
	logic clk_i, rst_n_i, reg_wr, reg_rd, su_scan, slow;
	logic flash_rd, flash_ack, stall, nmi, busy;
	logic [1:0] reg_addr, su_rgn;
	logic [7:0] reg_wdata, reg_rdata, flash_rdata;
	logic [15:0] flash_addr;
	int n_mismatch = 0;
	int cmp_count = 0;
	int exp_addr = 0;

	// flash reads must walk up from byte zero, one at a time
	always @(negedge clk_i) begin
		if (busy !== 1'b1) begin
			exp_addr = 0;
		end else if (flash_rd === 1'b1) begin
			chk(flash_addr[15:8], 8'(exp_addr >> 8));
			chk(flash_addr[7:0], 8'(exp_addr));
			exp_addr++;
		end
	end

	mis_scanner #(.AW(16), .FLASH_END(16'h00ff)) i_mis_scanner (
		.clk_i(clk_i), .rst_n_i(rst_n_i), .reg_addr_i(reg_addr),
		.reg_wdata_i(reg_wdata), .reg_wr_i(reg_wr), .reg_rd_i(reg_rd),
		.reg_rdata_o(reg_rdata), .loader_end_i(16'h001f),
		.program_end_i(16'h005f), .startup_scan_i(su_scan),
		.startup_region_i(su_rgn), .flash_rd_o(flash_rd),
		.flash_addr_o(flash_addr), .flash_ack_i(flash_ack),
		.flash_rdata_i(flash_rdata), .cpu_stall_o(stall), .nmi_o(nmi),
		.busy_o(busy));
	mis_flash_model i_mis_flash_model (.clk_i(clk_i), .rd_i(flash_rd),
		.addr_i(flash_addr), .slow_i(slow), .ack_o(flash_ack),
		.rdata_o(flash_rdata));

	initial begin
		clk_i = 1'b0;
		forever #10 clk_i = ~clk_i;
	end

	task automatic chk(input logic [7:0] got, input logic [7:0] exp);
		cmp_count++;
		if (got !== exp) begin
			n_mismatch++;
			$display("MISMATCH t=%0t got %h exp %h", $time, got, exp);
		end
	endtask

	task automatic wr(input logic [1:0] a, input logic [7:0] d);
		@(posedge clk_i);
		reg_addr <= a;
		reg_wdata <= d;
		reg_wr <= 1'b1;
		@(posedge clk_i);
		reg_wr <= 1'b0;
	endtask

	task automatic rd(input logic [1:0] a, input logic [7:0] exp);
		@(posedge clk_i);
		reg_addr <= a;
		reg_rd <= 1'b1;
		@(posedge clk_i);
		reg_rd <= 1'b0;
		@(negedge clk_i);
		chk(reg_rdata, exp);
	endtask

	task automatic wait_idle();
		int n;
		n = 0;
		@(negedge clk_i);
		while (busy !== 1'b0 && n < 3000) begin
			@(negedge clk_i);
			n++;
		end
		chk({7'h0, busy}, 8'h00);
	endtask

	// random image with checksum in the last two bytes, msb first
	task automatic fill(input int e, input bit good);
		logic [15:0] c;
		int k;
		for (int i = 0; i <= e; i++) i_mis_flash_model.mem[i] = 8'($urandom);
		c = 16'hffff;
		for (int i = 0; i < e - 1; i++)
			for (int b = 7; b >= 0; b--)
				c = {c[14:0], 1'b0} ^
					((c[15] ^ i_mis_flash_model.mem[i][b]) ? 16'h1021 : 16'h0);
		i_mis_flash_model.mem[e - 1] = c[15:8];
		i_mis_flash_model.mem[e] = c[7:0];
		k = $urandom_range(0, e - 2);
		if (!good) i_mis_flash_model.mem[k] ^= 8'h01;
	endtask

	task automatic run_scan(input logic [1:0] s, input bit good, input bit arm);
		fill(s == 2'h1 ? 95 : s == 2'h2 ? 31 : 255, good);
		slow <= 1'($urandom_range(0, 1));
		wr(OFS_REGION, {6'h0, s});
		wr(OFS_CONTROL, {6'h0, arm, 1'b1});
		for (int i = 0; i < 4; i++) begin
			@(negedge clk_i);
			chk({6'h0, busy, stall}, {6'h0, 1'b1, i == 3});
		end
		wait_idle();
		rd(OFS_STATUS, {6'h0, good, 1'b0});
		chk({7'h0, nmi}, {7'h0, arm & ~good});
	endtask

	task automatic tally_and_finish();
		$display("compares %0d mismatches %0d", cmp_count, n_mismatch);
		if (n_mismatch == 0 && cmp_count > 0) begin
			$display("[ PASS ]");
		end else begin
			$display("[ FAIL ]");
		end
		$finish;
	endtask

	initial begin
		#(20 * 60000);
		n_mismatch++;
		tally_and_finish();
	end

	initial begin
		void'($urandom(32'hca9f3f33));
		rst_n_i = 1'b0;
		{reg_addr, reg_wdata, reg_wr, reg_rd, su_scan, su_rgn, slow} = '0;
		repeat (8) @(posedge clk_i);
		rst_n_i <= 1'b1;
		repeat (2) @(posedge clk_i);
		for (int i = 0; i < 4; i++) rd(i[1:0], i == 2 ? 8'h02 : 8'h00);
		for (int s = 0; s < 4; s++) begin
			run_scan(s[1:0], 1'b1, 1'b0);
			rd(OFS_CONTROL, 8'h01);
			rd(OFS_REGION, {6'h0, s[1:0]});
		end
		run_scan(2'h1, 1'b0, 1'b0);
		$display("region scans done");
		fill(31, 1'b1);
		wr(OFS_REGION, 8'h02);
		wr(OFS_CONTROL, 8'h01);
		wr(OFS_REGION, 8'h31);
		wr(OFS_CONTROL, 8'h02);
		wr(OFS_CONTROL, 8'h00);
		rd(OFS_CONTROL, 8'h01);
		rd(OFS_REGION, 8'h02);
		rd(OFS_STATUS, 8'h01);
		wr(OFS_CONTROL, 8'h80);
		@(negedge clk_i);
		chk({6'h0, busy, stall}, 8'h00);
		rd(OFS_CONTROL, 8'h00);
		rd(OFS_REGION, 8'h00);
		rd(OFS_STATUS, 8'h00);
		$display("busy protection done");
		wr(OFS_CONTROL, 8'h42);
		rd(OFS_CONTROL, 8'h02);
		fill(31, 1'b1);
		wr(OFS_REGION, 8'h02);
		wr(OFS_CONTROL, 8'h03);
		wr(OFS_CONTROL, 8'h80);
		@(negedge clk_i);
		chk({7'h0, busy}, 8'h01);
		wait_idle();
		wr(OFS_CONTROL, 8'h80);
		rd(OFS_CONTROL, 8'h02);
		run_scan(2'h2, 1'b0, 1'b1);
		wr(OFS_CONTROL, 8'h80);
		wr(OFS_REGION, 8'h01);
		wr(OFS_CONTROL, 8'h01);
		rd(OFS_CONTROL, 8'h03);
		rd(OFS_REGION, 8'h02);
		chk({6'h0, busy, nmi}, 8'h01);
		$display("failure interrupt done");
		fill(31, 1'b1);
		@(posedge clk_i);
		su_scan <= 1'b1;
		su_rgn <= 2'h2;
		rst_n_i <= 1'b0;
		repeat (2) @(posedge clk_i);
		rst_n_i <= 1'b1;
		@(posedge clk_i);
		su_scan <= 1'b0;
		@(posedge clk_i);
		wait_idle();
		rd(OFS_CONTROL, 8'h01);
		rd(OFS_REGION, 8'h12);
		rd(OFS_STATUS, 8'h02);
		chk({7'h0, nmi}, 8'h00);
		wr(OFS_REGION, 8'h02);
		rd(OFS_REGION, 8'h02);
		$display("start-up scan done");
		tally_and_finish();
	end
endmodule
